// ===== pkg/mid_pkg.sv
// Constants, types and state layout of the data-move decoder
package mid_pkg;

  // ==========================================================
  // Widths
  localparam int MID_WORD_W = 16;
  localparam int MID_DATA_W = 8;
  localparam int MID_ADDR_W = 12;

  // ==========================================================
  // Opcode fields
  localparam logic [7:0] MID_OPC_LDBANK = 8'h01;
  localparam logic [7:0] MID_OPC_LDWORK = 8'h0E;
  localparam logic [6:0] MID_OPC_STORE  = 7'h37;
  localparam logic [3:0] MID_OPC_FF_SRC = 4'hC;
  localparam logic [3:0] MID_OPC_FF_DST = 4'hF;

  // ==========================================================
  // Access bank layout
  localparam logic [7:0] MID_ACC_SPLIT   = 8'h80;
  localparam logic [3:0] MID_ACC_LO_PAGE = 4'h0;
  localparam logic [3:0] MID_ACC_HI_PAGE = 4'hF;

  // ==========================================================
  // Special file addresses (defaults of top-level parameters)
  localparam logic [11:0] MID_DEF_PC_LOW_BYTE_ADDR     = 12'hFF9;
  localparam logic [11:0] MID_DEF_STACK_TOP_LOW_ADDR   = 12'hFFD;
  localparam logic [11:0] MID_DEF_STACK_TOP_HIGH_ADDR  = 12'hFFE;
  localparam logic [11:0] MID_DEF_STACK_TOP_UPPER_ADDR = 12'hFFF;
  localparam logic [11:0] MID_DEF_WORK_ADDR            = 12'hFE8;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  MID_RST_BANK = 8'h00;
  localparam logic [7:0]  MID_RST_WORK = 8'h00;
  localparam logic [11:0] MID_RST_ADDR = 12'h000;
  localparam logic [15:0] MID_RST_WORD = 16'h0000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MID_Q1,
    MID_Q2,
    MID_Q3,
    MID_Q4
  } mid_phase_t;

  typedef enum logic [2:0] {
    MID_OP_NONE,
    MID_OP_LDBANK,
    MID_OP_LDWORK,
    MID_OP_STORE,
    MID_OP_FF_SRC,
    MID_OP_FF_DST
  } mid_op_t;

  typedef struct packed {
    logic [MID_ADDR_W-1:0] addr;
    logic                  rd;
    logic                  wr;
    logic [MID_DATA_W-1:0] wdata;
  } mid_mem_req_t;

  typedef struct packed {
    mid_phase_t            phase;
    mid_op_t               op;
    logic [MID_WORD_W-1:0] word;
    logic                  ff_pending;
    logic [MID_DATA_W-1:0] src_data;
    logic [MID_DATA_W-1:0] bank;
    logic [MID_DATA_W-1:0] work;
    mid_mem_req_t          mem;
    logic                  taken;
    logic                  refused;
    logic                  broken_pair;
  } mid_state_t;

endpackage

// ===== src/mid_addr_gen.sv
// Data address former for banked and access-bank file operands
module mid_addr_gen
  import mid_pkg::*;
(
  input  wire logic                  bank_mode,
  input  wire logic [MID_DATA_W-1:0] bank_sel,
  input  wire logic [7:0]            file_field,
  output logic      [MID_ADDR_W-1:0] data_addr
);

  always_comb begin
    if (bank_mode) begin
      // Bank select supplies the page, field the offset
      data_addr = {bank_sel[3:0], file_field};
    end else if (file_field < MID_ACC_SPLIT) begin
      data_addr = {MID_ACC_LO_PAGE, file_field};
    end else begin
      data_addr = {MID_ACC_HI_PAGE, file_field};
    end
  end

endmodule

// ===== src/mid_core.sv
// Decode and execute of literal, store and file-to-file data moves
module mid_core
  import mid_pkg::*;
#(
  parameter logic [MID_ADDR_W-1:0] PC_LOW_BYTE_ADDR     = MID_DEF_PC_LOW_BYTE_ADDR,
  parameter logic [MID_ADDR_W-1:0] STACK_TOP_LOW_ADDR   = MID_DEF_STACK_TOP_LOW_ADDR,
  parameter logic [MID_ADDR_W-1:0] STACK_TOP_HIGH_ADDR  = MID_DEF_STACK_TOP_HIGH_ADDR,
  parameter logic [MID_ADDR_W-1:0] STACK_TOP_UPPER_ADDR = MID_DEF_STACK_TOP_UPPER_ADDR,
  parameter logic [MID_ADDR_W-1:0] WORK_ADDR            = MID_DEF_WORK_ADDR
)
(
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic                  instr_valid,
  input  wire logic [MID_WORD_W-1:0] instr_word,
  input  wire logic [MID_DATA_W-1:0] mem_rdata,
  output logic      [1:0]            q_phase_ff,
  output logic                       instr_taken_ff,
  output logic      [MID_ADDR_W-1:0] mem_addr_ff,
  output logic                       mem_rd_ff,
  output logic                       mem_wr_ff,
  output logic      [MID_DATA_W-1:0] mem_wdata_ff,
  output logic      [MID_DATA_W-1:0] bank_select_reg_ff,
  output logic      [MID_DATA_W-1:0] work_reg_ff,
  output logic                       dest_refused_ff,
  output logic                       broken_pair_ff
);

  // ==========================================================
  // Decode helpers
  function automatic mid_op_t mid_decode(input logic [MID_WORD_W-1:0] w,
                                         input logic                  pend);
    mid_op_t op;
    op = MID_OP_NONE;
    // Second word of a pending move outranks every other decode
    if (pend && (w[15:12] == MID_OPC_FF_DST)) begin
      op = MID_OP_FF_DST;
    end else if (w[15:8] == MID_OPC_LDBANK) begin
      op = MID_OP_LDBANK;
    end else if (w[15:8] == MID_OPC_LDWORK) begin
      op = MID_OP_LDWORK;
    end else if (w[15:9] == MID_OPC_STORE) begin
      op = MID_OP_STORE;
    end else if (w[15:12] == MID_OPC_FF_SRC) begin
      op = MID_OP_FF_SRC;
    end
    return op;
  endfunction

  function automatic logic mid_protected(input logic [MID_ADDR_W-1:0] a);
    return (a == PC_LOW_BYTE_ADDR) || (a == STACK_TOP_LOW_ADDR) ||
           (a == STACK_TOP_HIGH_ADDR) || (a == STACK_TOP_UPPER_ADDR);
  endfunction

  function automatic logic mid_is_work(input logic [MID_ADDR_W-1:0] a);
    return a == WORK_ADDR;
  endfunction

  // ==========================================================
  // State
  mid_state_t            st_ff;
  mid_state_t            nxt_st;
  mid_op_t               in_op;
  logic [MID_ADDR_W-1:0] store_addr;
  logic [MID_ADDR_W-1:0] dst_addr;
  logic                  src_is_work;
  logic                  dst_is_work;

  // ==========================================================
  // Operand addresses
  assign in_op       = mid_decode(instr_word, st_ff.ff_pending);
  assign dst_addr    = st_ff.word[MID_ADDR_W-1:0];
  assign src_is_work = mid_is_work(st_ff.mem.addr);
  assign dst_is_work = mid_is_work(dst_addr);

  mid_addr_gen u_addr_gen (
    .bank_mode  (instr_word[8]),
    .bank_sel   (st_ff.bank),
    .file_field (instr_word[7:0]),
    .data_addr  (store_addr)
  );

  // ==========================================================
  // Phase sequencer and execute
  always_comb begin
    nxt_st = st_ff;
    // Pulses stand one cycle unless set again below
    nxt_st.taken = 1'b0;
    nxt_st.refused = 1'b0;
    nxt_st.broken_pair = 1'b0;
    case (st_ff.phase)
      MID_Q1: begin
        // Decode: take a word, issue the operand read for Q2
        nxt_st.phase = MID_Q2;
        nxt_st.mem.wr = 1'b0;
        nxt_st.op = MID_OP_NONE;
        if (instr_valid) begin
          nxt_st.taken = 1'b1;
          nxt_st.word = instr_word;
          nxt_st.op = in_op;
          if (st_ff.ff_pending && (in_op != MID_OP_FF_DST)) begin
            nxt_st.broken_pair = 1'b1;
            nxt_st.src_data = MID_RST_WORK;
          end
          nxt_st.ff_pending = 1'b0;
          if (in_op == MID_OP_STORE) begin
            nxt_st.mem.addr = store_addr;
            nxt_st.mem.rd = 1'b1;
          end else if (in_op == MID_OP_FF_SRC) begin
            nxt_st.mem.addr = instr_word[MID_ADDR_W-1:0];
            nxt_st.mem.rd = 1'b1;
          end
        end
      end
      MID_Q2: begin
        // Read: sample the source byte of a file move
        nxt_st.phase = MID_Q3;
        nxt_st.mem.rd = 1'b0;
        if (st_ff.op == MID_OP_FF_SRC) begin
          if (src_is_work) begin
            nxt_st.src_data = st_ff.work;
          end else begin
            nxt_st.src_data = mem_rdata;
          end
        end
      end
      MID_Q3: begin
        // Process: prepare the destination write for Q4
        nxt_st.phase = MID_Q4;
        case (st_ff.op)
          MID_OP_LDBANK: begin
            nxt_st.bank = st_ff.word[7:0];
          end
          MID_OP_LDWORK: begin
            nxt_st.work = st_ff.word[7:0];
          end
          MID_OP_STORE: begin
            nxt_st.mem.wr = 1'b1;
            nxt_st.mem.wdata = st_ff.work;
          end
          MID_OP_FF_DST: begin
            if (mid_protected(dst_addr)) begin
              nxt_st.refused = 1'b1;
            end else begin
              nxt_st.mem.addr = dst_addr;
              nxt_st.mem.wr = 1'b1;
              nxt_st.mem.wdata = st_ff.src_data;
              if (dst_is_work) begin
                nxt_st.work = st_ff.src_data;
              end
            end
          end
          default: begin
          end
        endcase
      end
      MID_Q4: begin
        // Write: strobe drops at the end of Q4
        nxt_st.phase = MID_Q1;
        nxt_st.mem.wr = 1'b0;
        if (st_ff.op == MID_OP_FF_SRC) begin
          nxt_st.ff_pending = 1'b1;
        end
      end
      default: begin
        nxt_st.phase = MID_Q1;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff.phase       <= MID_Q1;
      st_ff.op          <= MID_OP_NONE;
      st_ff.word        <= MID_RST_WORD;
      st_ff.ff_pending  <= 1'b0;
      st_ff.src_data    <= MID_RST_WORK;
      st_ff.bank        <= MID_RST_BANK;
      st_ff.work        <= MID_RST_WORK;
      st_ff.mem.addr    <= MID_RST_ADDR;
      st_ff.mem.rd      <= 1'b0;
      st_ff.mem.wr      <= 1'b0;
      st_ff.mem.wdata   <= MID_RST_WORK;
      st_ff.taken       <= 1'b0;
      st_ff.refused     <= 1'b0;
      st_ff.broken_pair <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  // Instruction port
  assign q_phase_ff         = st_ff.phase;
  assign instr_taken_ff     = st_ff.taken;

  // Data memory port
  assign mem_addr_ff        = st_ff.mem.addr;
  assign mem_rd_ff          = st_ff.mem.rd;
  assign mem_wr_ff          = st_ff.mem.wr;
  assign mem_wdata_ff       = st_ff.mem.wdata;

  // Core registers
  assign bank_select_reg_ff = st_ff.bank;
  assign work_reg_ff        = st_ff.work;

  // One-cycle flags
  assign dest_refused_ff    = st_ff.refused;
  assign broken_pair_ff     = st_ff.broken_pair;

endmodule

// ===== verif/mid_core_assertions.sv
// Port checker of the data-move decoder
module mid_core_assertions
  import mid_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  arst_n,
  input wire logic                  instr_valid,
  input wire logic [MID_WORD_W-1:0] instr_word,
  input wire logic [MID_DATA_W-1:0] mem_rdata,
  input wire logic [1:0]            q_phase_ff,
  input wire logic                  instr_taken_ff,
  input wire logic [MID_ADDR_W-1:0] mem_addr_ff,
  input wire logic                  mem_rd_ff,
  input wire logic                  mem_wr_ff,
  input wire logic [MID_DATA_W-1:0] mem_wdata_ff,
  input wire logic [MID_DATA_W-1:0] bank_select_reg_ff,
  input wire logic [MID_DATA_W-1:0] work_reg_ff,
  input wire logic                  dest_refused_ff,
  input wire logic                  broken_pair_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic take;
  assign take = (q_phase_ff == 2'h0) && instr_valid;
  property p_taken; take |=> instr_taken_ff && q_phase_ff == 2'h1; endproperty
  a_taken: assert property (p_taken) else $error("take pulse wrong");
  property p_ldbank; take && instr_word[15:8] == MID_OPC_LDBANK |=> !mem_rd_ff ##2
    bank_select_reg_ff == $past(instr_word[7:0], 3) && !mem_wr_ff; endproperty
  a_ldbank: assert property (p_ldbank) else $error("bank load wrong");
  property p_ldwork; take && instr_word[15:8] == MID_OPC_LDWORK |=> ##2
    work_reg_ff == $past(instr_word[7:0], 3); endproperty
  a_ldwork: assert property (p_ldwork) else $error("work load wrong");
  property p_store; take && instr_word[15:9] == MID_OPC_STORE |=> mem_rd_ff ##2
    mem_wr_ff && mem_wdata_ff == work_reg_ff; endproperty
  a_store: assert property (p_store) else $error("store wrong");
  property p_acc; take && instr_word[15:8] == 8'h6E |=> mem_addr_ff ==
    {($past(instr_word[7]) ? 4'hF : 4'h0), $past(instr_word[7:0])}; endproperty
  a_acc: assert property (p_acc) else $error("access address wrong");
  property p_bank; take && instr_word[15:8] == 8'h6F |=> mem_addr_ff ==
    {$past(bank_select_reg_ff[3:0]), $past(instr_word[7:0])}; endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_ffsrc; take && instr_word[15:12] == MID_OPC_FF_SRC |=>
    mem_rd_ff && mem_addr_ff == $past(instr_word[11:0]); endproperty
  a_ffsrc: assert property (p_ffsrc) else $error("move source wrong");
  property p_wrq; mem_wr_ff |-> q_phase_ff == 2'h3 && !$past(mem_wr_ff); endproperty
  a_wrq: assert property (p_wrq) else $error("write phase wrong");
  property p_refuse; dest_refused_ff |-> !mem_wr_ff && q_phase_ff == 2'h3; endproperty
  a_refuse: assert property (p_refuse) else $error("refused dest written");
  property p_broken; broken_pair_ff |-> q_phase_ff == 2'h1 && instr_taken_ff; endproperty
  a_broken: assert property (p_broken) else $error("broken pair pulse wrong");
endmodule

// ===== verif/mid_mem_model.sv
// Behavioural data memory facing the decoder
module mid_mem_model
  import mid_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic [MID_ADDR_W-1:0] mem_addr_ff,
  input  wire logic                  mem_rd_ff,
  input  wire logic                  mem_wr_ff,
  input  wire logic [MID_DATA_W-1:0] mem_wdata_ff,
  output logic      [MID_DATA_W-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [MID_DATA_W-1:0] mem [0:4095];
  logic [MID_DATA_W-1:0] last = 8'h00;
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
  // Not reading: show inverse of last value
  assign mem_rdata = mem_rd_ff ? mem[mem_addr_ff] : ~last;
  always @(posedge mclk) begin
    if (mem_rd_ff) last <= mem[mem_addr_ff];
    if (mem_wr_ff) mem[mem_addr_ff] <= mem_wdata_ff;
  end
endmodule

// ===== verif/tb.sv
// Self-checking bench of the data-move decoder
module tb
  import mid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0] mem_rdata, mem_wdata_ff, bank_select_reg_ff, work_reg_ff;
  logic [11:0] mem_addr_ff;
  logic [1:0] q_phase_ff;
  logic instr_taken_ff, mem_rd_ff, mem_wr_ff, dest_refused_ff, broken_pair_ff;
  int error_cnt = 0;
  int total_checks = 0;
  always #10 mclk = ~mclk;
  mid_core u_mid_core (.mclk, .arst_n, .instr_valid, .instr_word, .mem_rdata, .q_phase_ff,
    .instr_taken_ff, .mem_addr_ff, .mem_rd_ff, .mem_wr_ff, .mem_wdata_ff,
    .bank_select_reg_ff, .work_reg_ff, .dest_refused_ff, .broken_pair_ff);
  mid_mem_model u_mid_mem_model (.mclk, .mem_addr_ff, .mem_rd_ff, .mem_wr_ff,
    .mem_wdata_ff, .mem_rdata);
  task automatic report_and_stop;
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic exec(input logic [15:0] w);
    int n;
    n = 0;
    while (q_phase_ff !== 2'h0) begin
      @(negedge mclk);
      n++;
      if (n > 8) begin
        error_cnt++;
        report_and_stop();
      end
    end
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge mclk);
    instr_valid = 1'b0;
    chk("taken", 12'h001, {11'h0, instr_taken_ff});
  endtask
  task automatic t_literals;
    exec(16'h01A5);
    exec(16'h0EFF);
    repeat (2) @(negedge mclk);
    chk("bank", 12'h0A5, {4'h0, bank_select_reg_ff});
    chk("work", 12'h0FF, {4'h0, work_reg_ff});
  endtask
  task automatic t_store_acc;
    exec(16'h0E3C);
    exec(16'h6E85);
    exec(16'h6E10);
    repeat (3) @(negedge mclk);
    chk("acc_hi", 12'h03C, {4'h0, u_mid_mem_model.mem[12'hF85]});
    chk("acc_lo", 12'h03C, {4'h0, u_mid_mem_model.mem[12'h010]});
  endtask
  task automatic t_store_bank;
    exec(16'h0132);
    exec(16'h0E5A);
    exec(16'h6FFF);
    exec(16'h6F00);
    repeat (3) @(negedge mclk);
    chk("bank_top", 12'h05A, {4'h0, u_mid_mem_model.mem[12'h2FF]});
    chk("bank_bot", 12'h05A, {4'h0, u_mid_mem_model.mem[12'h200]});
  endtask
  task automatic t_move;
    u_mid_mem_model.mem[12'h345] = 8'h77;
    exec(16'hC345);
    exec(16'hF567);
    repeat (3) @(negedge mclk);
    chk("move_dst", 12'h077, {4'h0, u_mid_mem_model.mem[12'h567]});
    chk("move_src", 12'h077, {4'h0, u_mid_mem_model.mem[12'h345]});
    exec(16'h0E96);
    exec(16'hCFE8);
    exec(16'hF0AB);
    repeat (3) @(negedge mclk);
    chk("move_from_work", 12'h096, {4'h0, u_mid_mem_model.mem[12'h0AB]});
    exec(16'hC345);
    exec(16'hFFE8);
    repeat (3) @(negedge mclk);
    chk("move_to_work", 12'h077, {4'h0, work_reg_ff});
  endtask
  task automatic t_refuse;
    logic [11:0] dst [4];
    logic        seen;
    dst = '{MID_DEF_PC_LOW_BYTE_ADDR, MID_DEF_STACK_TOP_LOW_ADDR,
            MID_DEF_STACK_TOP_HIGH_ADDR, MID_DEF_STACK_TOP_UPPER_ADDR};
    for (int i = 0; i < 4; i++) begin
      seen = 1'b0;
      u_mid_mem_model.mem[dst[i]] = 8'h11;
      exec(16'hC345);
      exec({4'hF, dst[i]});
      repeat (3) begin
        @(negedge mclk);
        seen |= dest_refused_ff;
      end
      chk("protected_kept", 12'h011, {4'h0, u_mid_mem_model.mem[dst[i]]});
      chk("refused", 12'h001, {11'h0, seen});
    end
  endtask
  task automatic t_broken;
    u_mid_mem_model.mem[12'h123] = 8'h5E;
    exec(16'hC123);
    exec(16'h0E42);
    chk("broken", 12'h001, {11'h0, broken_pair_ff});
    exec(16'hF456);
    chk("lone_dst_pulse", 12'h000, {11'h0, broken_pair_ff});
    repeat (3) @(negedge mclk);
    chk("lone_dst", 12'h000, {4'h0, u_mid_mem_model.mem[12'h456]});
    chk("work_after_break", 12'h042, {4'h0, work_reg_ff});
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    arst_n = 1'b1;
    t_literals();
    t_store_acc();
    t_store_bank();
    t_move();
    t_refuse();
    t_broken();
    report_and_stop();
  end
endmodule
bind mid_core mid_core_assertions u_mid_core_assertions (.mclk, .arst_n, .instr_valid,
  .instr_word, .mem_rdata, .q_phase_ff, .instr_taken_ff, .mem_addr_ff, .mem_rd_ff,
  .mem_wr_ff, .mem_wdata_ff, .bank_select_reg_ff, .work_reg_ff, .dest_refused_ff,
  .broken_pair_ff);
